// ==== rtl/ccr_regs.sv ====
// Purpose: card control and device control registers of a dual socket bridge
// Assumes: configuration byte writes/reads with function number, synchronous to clk
// Notes:   global bits live once, are written only through function 0 and are read through either function
`timescale 1ns/1ps
module ccr_regs
   import ccr_pkg::*;
(
   input  wire logic       clk,                        // 25 MHz clock
   input  wire logic       reset_n,                    // sync reset, active low
   // configuration access
   input  wire logic       cfg_wr,                     // byte write strobe
   input  wire logic       cfg_rd,                     // byte read strobe
   input  wire logic       cfg_func,                   // function number 0 or 1
   input  wire logic [7:0] cfg_addr,                   // byte offset
   input  wire logic [7:0] cfg_wdata,                  // write data
   output logic      [7:0] cfg_rdata,                  // registered read data
   // socket side
   input  wire logic [1:0] card_irq_event,             // functional interrupt per socket
   input  wire logic [1:0] card_speaker_input,         // speaker per socket
   input  wire logic [1:0] card_audio_input,           // audio per socket
   input  wire logic       ring_indicate_input,        // internal ring event
   input  wire logic       ring_terminal_select,       // 0 routes to ring/wake pin
   input  wire logic [1:0] power_down_req,             // software power down request per socket
   input  wire logic       in_d3,                      // function in D3
   output logic      [1:0] socket_power_down,          // power down granted
   output logic            ring_indicate_output,       // ring/wake terminal
   output logic            multipurpose_ring_output,   // ring on terminal two or four
   output logic      [1:0] video_port_tristate_enable, // video pins high impedance
   output logic            video_select_first,         // socket 0 video owner
   output logic            video_select_second,        // socket 1 video owner
   output logic            audio_pwm_output,           // routed card audio
   output logic            speaker_output,             // speaker data
   output logic            speaker_output_oe,          // speaker pin drive enable
   output logic      [1:0] card_interrupt_flag,        // per socket flags
   output logic            low_voltage_capable_force,  // 3-V capability report
   output logic            diagnostic_io_bit,          // diagnostic bit
   output ccr_mode_t       interrupt_signal_select     // interrupt signalling mode
);
   // ****************************************
   // storage
   // ****************************************
   logic [7:0] cc_global_r;        // ring enable only
   logic [7:0] cc_local_r [2];     // video, port select, audio, speaker
   logic [7:0] dc_global_r;        // capability, test bits
   logic [7:0] dc_shared_r;        // lock, diag, mode
   logic [7:0] rd_nxt;

   // ****************************************
   // decode
   // ****************************************
   wire hit_card   = (cfg_addr == CCR_OFS_CARD);
   wire hit_device = (cfg_addr == CCR_OFS_DEVICE);
   wire fn0        = (cfg_func == 1'b0);
   wire wr_card    = cfg_wr & hit_card;
   wire wr_device  = cfg_wr & hit_device;

   // global parts writable only through function 0
   wire wr_cc_global = wr_card & fn0;
   wire wr_dc_global = wr_device & fn0;

   // per-function card control storage, one copy per socket
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sock
         wire wr_local = wr_card & (cfg_func == 1'(gi));
         always_ff @(posedge clk) begin
            if (!reset_n)      cc_local_r[gi] <= CC_RESET;
            else if (wr_local) cc_local_r[gi] <= cfg_wdata & CC_LOCAL_MSK;
         end
         // write one to bit 0 clears; zero leaves it
         ccr_flag u_flag (
            .clk     (clk),
            .reset_n (reset_n),
            .set_ev  (card_irq_event[gi]),
            .clr_ev  (wr_local & cfg_wdata[CC_INT_FLAG]),
            .flag    (card_interrupt_flag[gi])
         );
      end
   endgenerate

   // shared ring enable, one copy for both functions
   always_ff @(posedge clk) begin
      if (!reset_n)          cc_global_r <= CC_RESET & CC_GLOBAL_MSK;
      else if (wr_cc_global) cc_global_r <= cfg_wdata & CC_GLOBAL_MSK;
   end

   // global device control bits: test bits are plain storage
   always_ff @(posedge clk) begin
      if (!reset_n)          dc_global_r <= DC_RESET & DC_GLOBAL_MSK;
      else if (wr_dc_global) dc_global_r <= cfg_wdata & DC_GLOBAL_MSK;
   end

   // remaining device bits shared and written from either function
   always_ff @(posedge clk) begin
      if (!reset_n)       dc_shared_r <= DC_RESET & DC_LOCAL_MSK;
      else if (wr_device) dc_shared_r <= cfg_wdata & DC_LOCAL_MSK;
   end

   // ****************************************
   // read path
   // ****************************************
   // reserved bits 4,3 of card control and 4 of device control never stored
   wire [7:0] cc_view = cc_global_r | cc_local_r[cfg_func]
                      | {7'h00, card_interrupt_flag[cfg_func]};
   wire [7:0] dc_view = dc_global_r | dc_shared_r;

   always_comb begin
      rd_nxt = 8'h00;
      if (cfg_rd && hit_card)   rd_nxt = cc_view;
      if (cfg_rd && hit_device) rd_nxt = dc_view;
   end

   // read data held until the next read
   always_ff @(posedge clk) begin
      if (!reset_n)    cfg_rdata <= 8'h00;
      else if (cfg_rd) cfg_rdata <= rd_nxt;
   end

   // ****************************************
   // ring routing
   // ****************************************
   wire ring_en = cc_global_r[CC_RING_EN];
   // gate ring before either destination so disable blocks all paths
   assign ring_indicate_output     = ring_en & ~ring_terminal_select & ring_indicate_input;
   assign multipurpose_ring_output = ring_en & ring_indicate_input;

   // ****************************************
   // zoomed video
   // ****************************************
   wire zv0 = cc_local_r[0][CC_VIDEO_TRI];
   wire zv1 = cc_local_r[1][CC_VIDEO_TRI];
   // port select is taken from function 0's copy
   wire psel = cc_local_r[0][CC_PORT_SEL];
   assign video_port_tristate_enable = {zv1, zv0};
   assign video_select_first  = zv0 & ~(zv1 & psel);
   assign video_select_second = zv1 & ~(zv0 & ~psel);

   // ****************************************
   // audio and speaker
   // ****************************************
   wire aud0 = cc_local_r[0][CC_AUDIO];
   wire aud1 = cc_local_r[1][CC_AUDIO];
   // socket 0 takes precedence when both route audio
   assign audio_pwm_output = aud0 ? card_audio_input[0]
                                  : (aud1 & card_audio_input[1]);

   wire spk0 = cc_local_r[0][CC_SPEAKER];
   wire spk1 = cc_local_r[1][CC_SPEAKER];
   // a disabled socket contributes zero so it cannot flip the other
   assign speaker_output    = (spk0 & card_speaker_input[0])
                            ^ (spk1 & card_speaker_input[1]);
   assign speaker_output_oe = spk0 | spk1;

   // ****************************************
   // device control outputs
   // ****************************************
   wire pwr_lock = dc_shared_r[DC_PWR_LOCK];
   // lock only matters in D3; outside D3 requests pass
   assign socket_power_down = power_down_req & ~{2{pwr_lock & in_d3}};
   assign low_voltage_capable_force = dc_global_r[DC_LV_CAP];
   assign diagnostic_io_bit         = dc_shared_r[DC_DIAG];
   assign interrupt_signal_select   = ccr_mode_t'(dc_shared_r[DC_MODE_LO +: 2]);
endmodule : ccr_regs

// ==== rtl/ccr_pkg.sv ====
// Purpose: constants for the card and device control register bank
// Assumes: 8-bit configuration byte access, two bridge functions
// Notes:   offsets are configuration byte addresses
package ccr_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] CCR_OFS_CARD   = 8'h91;
   localparam logic [7:0] CCR_OFS_DEVICE = 8'h92;

   // ****************************************
   // card control fields
   // ****************************************
   localparam int CC_RING_EN   = 7;
   localparam int CC_VIDEO_TRI = 6;
   localparam int CC_PORT_SEL  = 5;
   localparam int CC_AUDIO     = 2;
   localparam int CC_SPEAKER   = 1;
   localparam int CC_INT_FLAG  = 0;
   localparam logic [7:0] CC_RESET      = 8'h00;
   localparam logic [7:0] CC_GLOBAL_MSK = 8'h80;
   localparam logic [7:0] CC_LOCAL_MSK  = 8'h66;

   // ****************************************
   // device control fields
   // ****************************************
   localparam int DC_PWR_LOCK = 7;
   localparam int DC_LV_CAP   = 6;
   localparam int DC_DIAG     = 5;
   localparam int DC_MODE_LO  = 1;
   localparam logic [7:0] DC_RESET      = 8'h66;
   localparam logic [7:0] DC_GLOBAL_MSK = 8'h49;
   localparam logic [7:0] DC_LOCAL_MSK  = 8'hA6;

   // interrupt signalling modes
   typedef enum logic [1:0] {
      CCR_MODE_PCI_PAR  = 2'h0,
      CCR_MODE_IRQ_PAR  = 2'h1,
      CCR_MODE_IRQ_SER  = 2'h2,
      CCR_MODE_ALL_SER  = 2'h3
   } ccr_mode_t;
endpackage : ccr_pkg

// ==== rtl/ccr_flag.sv ====
// Purpose: one sticky write-one-to-clear interrupt flag
// Assumes: event and clear are single-cycle synchronous qualifiers
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module ccr_flag (
   input  wire logic clk,       // clock
   input  wire logic reset_n,   // sync reset, active low
   input  wire logic set_ev,    // functional interrupt seen
   input  wire logic clr_ev,    // write of one to the flag
   output logic      flag       // sticky flag
);
   logic flag_r;
   logic flag_nxt;

   // set beats clear so an event in the clearing cycle is kept
   assign flag_nxt = set_ev | (flag_r & ~clr_ev);
   assign flag     = flag_r;

   always_ff @(posedge clk) begin
      if (!reset_n) flag_r <= 1'b0;
      else          flag_r <= flag_nxt;
   end
endmodule : ccr_flag

// ==== tb/ccr_regs_properties.sv ====
// Purpose: port-level properties of the card and device control bank
// Assumes: one clock, synchronous active-low reset
// Notes:   register contents are judged only through outputs and reads
`timescale 1ns/1ps
module ccr_regs_properties
   import ccr_pkg::*;
(
   input wire logic       clk, reset_n, cfg_wr, cfg_rd, cfg_func,                 // clock, reset, strobes
   input wire logic [7:0] cfg_addr, cfg_wdata, cfg_rdata,                         // access bus
   input wire logic [1:0] card_irq_event, power_down_req, socket_power_down,      // socket side
   input wire logic [1:0] card_interrupt_flag,                                    // sticky flags
   input wire logic       ring_indicate_input, ring_terminal_select, in_d3,       // ring and power inputs
   input wire logic       ring_indicate_output, multipurpose_ring_output,         // ring routing
   input wire logic       video_select_first, video_select_second,                // video owner
   input wire logic       low_voltage_capable_force, diagnostic_io_bit,           // device bits
   input wire ccr_mode_t  interrupt_signal_select                                 // signalling mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_ring_off; !ring_indicate_input |-> !ring_indicate_output && !multipurpose_ring_output; endproperty
   a_ring_off: assert property (p_ring_off) else $error("ring routed with no ring");
   property p_ring_sel; ring_terminal_select |-> !ring_indicate_output; endproperty
   a_ring_sel: assert property (p_ring_sel) else $error("ring on wrong terminal");
   property p_flag_set; card_irq_event[0] |=> card_interrupt_flag[0]; endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag missed event");
   property p_flag_keep;
      card_interrupt_flag[1] && !(cfg_wr && cfg_func && cfg_addr == CCR_OFS_CARD && cfg_wdata[0])
      |=> card_interrupt_flag[1];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
   property p_pwr; (socket_power_down & ~power_down_req) == 2'h0 && (in_d3 || socket_power_down == power_down_req);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power down not from request");
   property p_rst; disable iff (1'b0) !reset_n |=> interrupt_signal_select == CCR_MODE_ALL_SER
      && low_voltage_capable_force && diagnostic_io_bit; endproperty
   a_rst: assert property (p_rst) else $error("device bits reset wrong");
   property p_rsvd; cfg_rd && cfg_addr == CCR_OFS_CARD |=> cfg_rdata[4:3] == 2'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_glob; cfg_wr && cfg_func && cfg_addr == CCR_OFS_DEVICE |=> $stable(low_voltage_capable_force); endproperty
   a_glob: assert property (p_glob) else $error("global bit written by function 1");
   property p_vid; !(video_select_first && video_select_second); endproperty
   a_vid: assert property (p_vid) else $error("two video owners");
endmodule : ccr_regs_properties
bind ccr_regs ccr_regs_properties chk (.*);

// ==== tb/ccr_socket_model.sv ====
// Purpose: behavioural stand-in for the two card sockets
// Assumes: runs off the bench clock
// Notes:   levels are redrawn at random every cycle so a stale path shows up
`timescale 1ns/1ps
module ccr_socket_model (
   input  wire logic       clk,                       // bench clock
   input  wire logic [1:0] irq_req,                   // bench asks for a card interrupt
   output logic      [1:0] card_irq_event     = 2'h0, // interrupt per socket
   output logic      [1:0] card_speaker_input = 2'h0, // speaker per socket
   output logic      [1:0] card_audio_input   = 2'h0  // audio per socket
);
   // live card audio looks random to the bridge
   always @(posedge clk) begin
      card_speaker_input <= 2'($urandom);
      card_audio_input   <= 2'($urandom);
      card_irq_event     <= irq_req;
   end
endmodule : ccr_socket_model

// ==== tb/card_device_control_regs_test.sv ====
// Purpose: self-checking bench for the card and device control bank
// Assumes: socket model drives the card side
// Notes:   test bits 3 and 0 of device control are only written as zero
`timescale 1ns/1ps
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin errors++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module card_device_control_regs_test;
   import ccr_pkg::*;
   logic       clk, reset_n, cfg_wr, cfg_rd, cfg_func, ring_indicate_input, ring_terminal_select, in_d3;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v;
   logic [1:0] card_irq_event, card_speaker_input, card_audio_input, power_down_req, socket_power_down, irq_req;
   logic [1:0] video_port_tristate_enable, card_interrupt_flag;
   logic       ring_indicate_output, multipurpose_ring_output, video_select_first, video_select_second;
   logic       audio_pwm_output, speaker_output, speaker_output_oe, low_voltage_capable_force, diagnostic_io_bit;
   ccr_mode_t  interrupt_signal_select;
   int         errors = 0, n_tests = 0, cyc = 0;
   ccr_regs uut (.*);
   ccr_socket_model sock (.clk(clk), .irq_req(irq_req), .card_irq_event(card_irq_event),
      .card_speaker_input(card_speaker_input), .card_audio_input(card_audio_input));
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic acc(input logic w, f, input logic [7:0] a, d);
      @(posedge clk);
      {cfg_wr, cfg_rd} <= {w, !w};
      {cfg_func, cfg_addr, cfg_wdata} <= {f, a, d};
      @(posedge clk);
      {cfg_wr, cfg_rd} <= 2'h0;
   endtask : acc
   task automatic rd(input logic f, input logic [7:0] a, e);
      acc(1'b0, f, a, 8'h00);
      @(negedge clk) `CHK(cfg_rdata, e)
   endtask : rd
   function automatic logic [1:0] ring_exp(input int k);
      return {k[1] & k < 4 & !k[0], k[1] & k < 4};
   endfunction : ring_exp
   // free-running clock and a ceiling on the run
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      v = 8'($urandom(73895));
      {cfg_wr, cfg_rd, cfg_func, ring_indicate_input, ring_terminal_select, in_d3, reset_n} = 7'h00;
      {cfg_addr, cfg_wdata, irq_req, power_down_req} = 20'h00000;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(0, CCR_OFS_CARD, CC_RESET);
      rd(1, CCR_OFS_DEVICE, DC_RESET);
      for (int m = 0; m < 4; m++) begin
         v = (8'($urandom) & 8'hF0) | 8'(m << 1);
         acc(1, 0, CCR_OFS_DEVICE, v);
         rd(1, CCR_OFS_DEVICE, v & 8'hEF);
         `CHK({interrupt_signal_select, low_voltage_capable_force, diagnostic_io_bit}, {2'(m), v[6:5]})
      end
      acc(1, 1, CCR_OFS_DEVICE, 8'h00);
      rd(0, CCR_OFS_DEVICE, v & 8'h40);
      @(posedge clk) {in_d3, power_down_req} <= 3'h7;
      for (int l = 0; l < 2; l++) begin
         acc(1, 0, CCR_OFS_DEVICE, l ? 8'h00 : 8'h80);
         @(negedge clk) `CHK(socket_power_down, l ? 2'h3 : 2'h0)
      end
      acc(1, 0, CCR_OFS_CARD, 8'hFE);
      rd(0, CCR_OFS_CARD, 8'hE6);
      acc(1, 1, CCR_OFS_CARD, 8'h40);
      rd(1, CCR_OFS_CARD, 8'hC0);
      for (int p = 0; p < 2; p++) begin
         acc(1, 0, CCR_OFS_CARD, 8'hC0 | 8'(p << 5));
         @(negedge clk) `CHK({video_port_tristate_enable, video_select_first, video_select_second}, {2'h3, p == 0, p == 1})
      end
      for (int k = 0; k < 8; k++) begin
         if (k == 4) acc(1, 0, CCR_OFS_CARD, 8'h40);
         if (k == 4) acc(1, 1, CCR_OFS_CARD, 8'hC0);
         @(posedge clk) {ring_indicate_input, ring_terminal_select} <= 2'(k);
         @(negedge clk) `CHK({ring_indicate_output, multipurpose_ring_output}, ring_exp(k))
      end
      for (int e = 0; e < 4; e++) begin
         acc(1, 0, CCR_OFS_CARD, e[0] ? 8'h06 : 8'h00);
         acc(1, 1, CCR_OFS_CARD, e[1] ? 8'h06 : 8'h00);
         repeat (4) @(negedge clk) begin
            `CHK(audio_pwm_output, e[0] ? card_audio_input[0] : e[1] & card_audio_input[1])
            `CHK({speaker_output_oe, speaker_output}, {e != 0, ^(card_speaker_input & 2'(e))})
         end
      end
      @(posedge clk) irq_req <= 2'h3;
      @(posedge clk) irq_req <= 2'h0;
      repeat (2) @(posedge clk);
      @(negedge clk) `CHK(card_interrupt_flag, 2'h3)
      acc(1, 1, CCR_OFS_CARD, 8'h01);
      acc(1, 0, CCR_OFS_CARD, 8'h00);
      @(negedge clk) `CHK(card_interrupt_flag, 2'h1)
      @(posedge clk) irq_req <= 2'h1;
      acc(1, 0, CCR_OFS_CARD, 8'h01);
      @(negedge clk) `CHK(card_interrupt_flag[0], 1'b1)
      @(posedge clk) irq_req <= 2'h0;
      acc(1, 0, CCR_OFS_CARD, 8'h01);
      @(negedge clk) `CHK(card_interrupt_flag[0], 1'b0)
      finish_test();
   end
endmodule : card_device_control_regs_test
